//--- design/uibg_core.sv
// Interrupt identification, enable, baud generator and scratch behind AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "uibg_map.svh"
module uibg_core #(
    parameter logic [31:0] CLK_KHZ = `UIBG_CLK_KHZ,
    parameter logic [31:0] REF_KHZ = `UIBG_REF_KHZ
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire uibg_pkg::uibg_line_t line_status,
    input  wire uibg_pkg::uibg_hs_t   handshake_status,
    input  wire logic          rx_data_ready,
    input  wire logic          rx_timeout,
    input  wire logic          tx_empty,
    input  wire logic          tx_buffer_write,
    output logic               irq_request,
    output logic               baud16_tick,
    output uibg_pkg::uibg_cfg_t config_out
);
    import uibg_pkg::*;

    generate
        if (REF_KHZ == 32'h0 || REF_KHZ >= CLK_KHZ) begin : g_bad_rate
            $error("Reference rate must be nonzero and below the clock rate");
        end
    endgenerate

    logic [7:0]     interrupt_enable;
    logic [7:0]     baud_divisor_low;
    logic [7:0]     baud_divisor_high;
    logic [7:0]     scratch_byte;
    uibg_cfg_t      cfg;
    logic [7:0]     interrupt_identification;
    logic [3:0]     next_code;
    logic           fifo_mode;
    logic           tx_pend;
    logic           tx_empty_d;
    logic           ier_tx_d;
    logic           ls_act;
    logic           rd_act;
    logic           to_act;
    logic           tx_act;
    logic           hs_act;
    logic           aw_held;
    logic           w_held;
    logic [7:0]     aw_addr;
    logic [31:0]    w_data;
    logic [3:0]     w_strb;
    logic           do_write;
    uibg_rd_state_t rd_state;
    logic           rd_take;
    logic           iid_read_tx;
    logic [31:0]    ref_acc;
    logic [32:0]    ref_sum;
    logic           ref_tick;
    logic [4:0]     pd_acc;
    logic [4:0]     pd_num;
    logic [4:0]     pd_den;
    logic [5:0]     pd_sum;
    logic           pre_tick;
    logic [15:0]    divisor;
    logic [15:0]    div_cnt;

    // FIFO mode follows enable bit
    // mode select
    assign fifo_mode  = cfg.fifo_enable;
    assign config_out = cfg;

    // Source activity gated by enables
    // enable gating
    assign ls_act = interrupt_enable[`UIBG_IER_LS] & (|line_status);
    assign rd_act = interrupt_enable[`UIBG_IER_RD] & rx_data_ready;
    assign to_act = interrupt_enable[`UIBG_IER_RD] & fifo_mode & rx_timeout;
    assign tx_act = interrupt_enable[`UIBG_IER_TX] & tx_pend;
    assign hs_act = interrupt_enable[`UIBG_IER_HS] & (|handshake_status);

    always_comb begin
        if (ls_act) begin
            next_code = `UIBG_CODE_LS;
        end else if (rd_act) begin
            next_code = `UIBG_CODE_RD;
        end else if (to_act) begin
            next_code = `UIBG_CODE_TO;
        end else if (tx_act) begin
            next_code = `UIBG_CODE_TX;
        end else if (hs_act) begin
            next_code = `UIBG_CODE_HS;
        end else begin
            next_code = `UIBG_CODE_NONE;
        end
    end

    assign interrupt_identification = {fifo_mode, fifo_mode, 2'b00, next_code};

    assign irq_request = ~next_code[0];

    // Transmit-empty latch, set wins over clear
    assign iid_read_tx = rd_take && (s_axi_araddr == `UIBG_OFF_IID)
                         && (next_code == `UIBG_CODE_TX);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_empty_d <= 1'b0;
            ier_tx_d   <= 1'b0;
        end else begin
            tx_empty_d <= tx_empty;
            ier_tx_d   <= interrupt_enable[`UIBG_IER_TX];
        end
    end
    // set on empty, clear on write or read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_pend <= 1'b0;
        end else if (tx_empty && (!tx_empty_d
                     || (interrupt_enable[`UIBG_IER_TX] && !ier_tx_d))) begin
            tx_pend <= 1'b1;
        end else if (tx_buffer_write || iid_read_tx || !tx_empty) begin
            tx_pend <= 1'b0;
        end
    end

    // AXI write channels, taken in either order
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;
    assign do_write      = aw_held & w_held & ~s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `UIBG_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
                `UIBG_OFF_IER, `UIBG_OFF_DLL, `UIBG_OFF_DLH,
                `UIBG_OFF_SCR, `UIBG_OFF_CFG, `UIBG_OFF_IID: begin
                    s_axi_bresp <= `UIBG_RESP_OKAY;
                end
                default: begin
                    s_axi_bresp <= `UIBG_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register storage, byte lane 0 only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_enable  <= `UIBG_RST_BYTE;
            baud_divisor_low  <= `UIBG_RST_BYTE;
            baud_divisor_high <= `UIBG_RST_BYTE;
            scratch_byte      <= `UIBG_RST_BYTE;
            cfg               <= `UIBG_RST_CFG;
        end else if (do_write && w_strb[0]) begin
            case (aw_addr)
                `UIBG_OFF_IER: begin
                    interrupt_enable <= {4'h0, w_data[3:0]};
                end
                `UIBG_OFF_DLL: begin
                    baud_divisor_low <= w_data[7:0];
                end
                `UIBG_OFF_DLH: begin
                    baud_divisor_high <= w_data[7:0];
                end
                `UIBG_OFF_SCR: begin
                    scratch_byte <= w_data[7:0];
                end
                `UIBG_OFF_CFG: begin
                    cfg <= w_data[3:0];
                end
                default: begin
                    cfg <= cfg;
                end
            endcase
        end
    end

    // AXI read: answer one cycle after address taken
    assign s_axi_arready = (rd_state == UIBG_RD_IDLE);
    assign rd_take       = s_axi_arvalid & s_axi_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= UIBG_RD_IDLE;
        end else begin
            case (rd_state)
                UIBG_RD_IDLE: begin
                    if (rd_take) begin
                        rd_state <= UIBG_RD_RESP;
                    end
                end
                UIBG_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state <= UIBG_RD_IDLE;
                    end
                end
                default: begin
                    rd_state <= UIBG_RD_IDLE;
                end
            endcase
        end
    end
    assign s_axi_rvalid = (rd_state == UIBG_RD_RESP);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `UIBG_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rresp <= `UIBG_RESP_OKAY;
            case (s_axi_araddr)
                `UIBG_OFF_IER: s_axi_rdata <= {24'h0, interrupt_enable};
                `UIBG_OFF_IID: s_axi_rdata <= {24'h0, interrupt_identification};
                `UIBG_OFF_DLL: s_axi_rdata <= {24'h0, baud_divisor_low};
                `UIBG_OFF_DLH: s_axi_rdata <= {24'h0, baud_divisor_high};
                `UIBG_OFF_SCR: s_axi_rdata <= {24'h0, scratch_byte};
                `UIBG_OFF_CFG: s_axi_rdata <= {28'h0, cfg};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `UIBG_RESP_SLVERR;
                end
            endcase
        end
    end

    // Reference enable from aclk by phase accumulation
    assign ref_sum = {1'b0, ref_acc} + {1'b0, REF_KHZ};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_acc  <= 32'h0;
            ref_tick <= 1'b0;
        end else if (ref_sum >= {1'b0, CLK_KHZ}) begin
            ref_acc  <= 32'(ref_sum - {1'b0, CLK_KHZ});
            ref_tick <= 1'b1;
        end else begin
            ref_acc  <= ref_sum[31:0];
            ref_tick <= 1'b0;
        end
    end

    always_comb begin
        if (cfg.high_speed_config) begin
            pd_num = `UIBG_PD1_NUM;
            pd_den = `UIBG_PD1_DEN;
        end else begin
            case (cfg.prediv_config)
                2'h0: begin
                    pd_num = `UIBG_PD13_NUM;
                    pd_den = `UIBG_PD13_DEN;
                end
                2'h1: begin
                    pd_num = `UIBG_PD1625_NUM;
                    pd_den = `UIBG_PD1625_DEN;
                end
                default: begin
                    pd_num = `UIBG_PD1_NUM;
                    pd_den = `UIBG_PD1_DEN;
                end
            endcase
        end
    end
    assign pd_sum = {1'b0, pd_acc} + {1'b0, pd_num};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pd_acc   <= 5'h0;
            pre_tick <= 1'b0;
        end else if (ref_tick) begin
            if (pd_sum >= {1'b0, pd_den}) begin
                pd_acc   <= 5'(pd_sum - {1'b0, pd_den});
                pre_tick <= 1'b1;
            end else begin
                pd_acc   <= pd_sum[4:0];
                pre_tick <= 1'b0;
            end
        end else begin
            pre_tick <= 1'b0;
        end
    end

    assign divisor = {baud_divisor_high, baud_divisor_low};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt     <= 16'h0;
            baud16_tick <= 1'b0;
        end else if (divisor == 16'h0) begin
            div_cnt     <= 16'h0;
            baud16_tick <= 1'b0;
        end else if (pre_tick) begin
            if (div_cnt + 16'h1 >= divisor) begin
                div_cnt     <= 16'h0;
                baud16_tick <= 1'b1;
            end else begin
                div_cnt     <= div_cnt + 16'h1;
                baud16_tick <= 1'b0;
            end
        end else begin
            baud16_tick <= 1'b0;
        end
    end

    a_id_top_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_take && s_axi_araddr == `UIBG_OFF_IID |=> s_axi_rdata[7:6] == {2{$past(fifo_mode)}})
        else $error("Identification top bits wrong");
    a_id_zero_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_take && s_axi_araddr == `UIBG_OFF_IID |=> s_axi_rdata[5:4] == 2'b00)
        else $error("Identification bits 5:4 not zero");
    a_timeout_code: assert property (@(posedge aclk) disable iff (!aresetn)
        !fifo_mode |-> !interrupt_identification[3])
        else $error("Timeout bit outside FIFO mode");
    a_no_pending: assert property (@(posedge aclk) disable iff (!aresetn)
        !(ls_act || rd_act || to_act || tx_act || hs_act) |-> interrupt_identification[0] && !irq_request)
        else $error("Pending shown without source");
    a_line_first: assert property (@(posedge aclk) disable iff (!aresetn)
        interrupt_enable[`UIBG_IER_LS] && (|line_status) |-> interrupt_identification[3:0] == 4'h6)
        else $error("Line status not top priority");
    a_tx_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_buffer_write && !(tx_empty && (!tx_empty_d || (interrupt_enable[`UIBG_IER_TX] && !ier_tx_d)))
        |=> !tx_pend)
        else $error("Transmit empty not cleared by write");
    a_ier_upper: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_take && s_axi_araddr == `UIBG_OFF_IER |=> s_axi_rdata[7:4] == 4'h0)
        else $error("Enable upper bits not zero");
    a_irq_off: assert property (@(posedge aclk) disable iff (!aresetn)
        interrupt_enable[3:0] == 4'h0 |-> !irq_request)
        else $error("Request with all enables clear");
    a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
        baud16_tick |=> !baud16_tick [*4])
        else $error("Sample ticks too close");

    c_line_irq: cover property (@(posedge aclk) disable iff (!aresetn)
        irq_request && interrupt_identification[3:0] == 4'h6);
    c_timeout: cover property (@(posedge aclk) disable iff (!aresetn)
        interrupt_identification[3:0] == 4'hc);
    c_tx_read_clear: cover property (@(posedge aclk) disable iff (!aresetn) iid_read_tx);
    c_tick: cover property (@(posedge aclk) disable iff (!aresetn) baud16_tick);
endmodule

//--- design/uibg_map.svh
// Register map, field positions, codes and rates of the interrupt-id and baud block
// Behaviour
// - Identification bits 7:6 read 1 when FIFO mode is on, else 0.
// - Identification bits 5:4 always read 0.
// - Bit 3 is 0 outside FIFO mode; timeout sets bits 3 and 2.
// - Bit 0 is 1 with nothing pending, 0 when any enabled source active.
// - Line error or break gives code 0110, top priority, cleared by status read.
// - Data ready or trigger level gives code 0100, second priority.
// - Receive FIFO timeout gives code 1100, third priority below data ready, cleared by reading data.
// - Transmit empty gives 0010; cleared by buffer write or identification read.
// - Handshake change flags give code 0000, lowest priority.
// - Enable register bits 7:4 always read 0.
// - Enable bits: 3 handshake, 2 line status, 1 transmit empty, 0 data ready.
// - No interrupt request while enable bits 3:0 are all clear.
// - Normal speed prescales 24 MHz to 1.8461 MHz, then 16-bit divisor 1..65535.
// - Divided output is the 16x sample base for transmitter and receiver.
// - High-speed mode feeds the divisor straight from 24 MHz.
// - Pre-divider of 13, 1.625 or 1.0 chosen by configuration.
// - Eight-bit scratch register, freely written and read back.
// - FIFO mode follows the FIFO enable bit.
// - Reading line status clears break, stop, parity and overrun flags.
`ifndef UIBG_MAP_SVH
`define UIBG_MAP_SVH
`define UIBG_OFF_IER      8'h04
`define UIBG_OFF_IID      8'h08
`define UIBG_OFF_DLL      8'h10
`define UIBG_OFF_DLH      8'h14
`define UIBG_OFF_SCR      8'h1c
`define UIBG_OFF_CFG      8'h20
`define UIBG_RST_BYTE     8'h00
`define UIBG_RST_CFG      4'h0
`define UIBG_IER_RD       0
`define UIBG_IER_TX       1
`define UIBG_IER_LS       2
`define UIBG_IER_HS       3
`define UIBG_CODE_NONE    4'h1
`define UIBG_CODE_LS      4'h6
`define UIBG_CODE_RD      4'h4
`define UIBG_CODE_TO      4'hc
`define UIBG_CODE_TX      4'h2
`define UIBG_CODE_HS      4'h0
`define UIBG_PD13_NUM     5'h01
`define UIBG_PD13_DEN     5'h0d
`define UIBG_PD1625_NUM   5'h08
`define UIBG_PD1625_DEN   5'h0d
`define UIBG_PD1_NUM      5'h01
`define UIBG_PD1_DEN      5'h01
`define UIBG_CLK_KHZ      32'h0001e848
`define UIBG_REF_KHZ      32'h00005dc0
`define UIBG_RESP_OKAY    2'h0
`define UIBG_RESP_SLVERR  2'h2
`endif

//--- design/uibg_pkg.sv
// Types shared by the interrupt-id and baud block
package uibg_pkg;
    typedef struct packed {
        logic overrun_flag;
        logic parity_error_flag;
        logic missing_stop_flag;
        logic break_flag;
    } uibg_line_t;
    typedef struct packed {
        logic cts_change_flag;
        logic dsr_change_flag;
        logic ring_trailing_edge_flag;
        logic dcd_change_flag;
    } uibg_hs_t;
    typedef struct packed {
        logic [1:0] prediv_config;
        logic       high_speed_config;
        logic       fifo_enable;
    } uibg_cfg_t;
    typedef enum logic [1:0] {
        UIBG_RD_IDLE = 2'b01,
        UIBG_RD_RESP = 2'b10
    } uibg_rd_state_t;
endpackage

//--- tb/uibg_core_tb.sv
// Self-checking bench of the interrupt-id and baud block
`timescale 1ns/10ps
`include "uibg_map.svh"
module uibg_core_tb;
    import uibg_pkg::*;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    uibg_line_t  line_in;
    uibg_hs_t    hs_in;
    logic        rx_rdy;
    logic        rx_to;
    logic        tx_emp;
    logic        tx_wr;
    logic        irq;
    logic        tick;
    uibg_cfg_t   cfg;
    int          num_errors;
    int          check_count;
    uibg_core uibg_core_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .line_status(line_in), .handshake_status(hs_in), .rx_data_ready(rx_rdy),
        .rx_timeout(rx_to), .tx_empty(tx_emp), .tx_buffer_write(tx_wr),
        .irq_request(irq), .baud16_tick(tick), .config_out(cfg)
    );
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic stop_test();
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw_busy;
        bit w_busy;
        bit done;
        aw_busy = 1'b1;
        w_busy = 1'b1;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge aclk);
            if (bvalid === 1'b1 && !aw_busy && !w_busy) begin
                chk(bresp, er);
                bready <= 1'b0;
                done = 1'b1;
            end
            if (aw_busy && awready === 1'b1) begin
                aw_busy = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_busy && wready === 1'b1) begin
                w_busy = 1'b0;
                wvalid <= 1'b0;
            end
        end
        if (!done) begin
            num_errors++;
            stop_test();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit ar_busy;
        bit done;
        ar_busy = 1'b1;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge aclk);
            if (rvalid === 1'b1 && !ar_busy) begin
                chk(rresp, er);
                chk(rdata, ed);
                rready <= 1'b0;
                done = 1'b1;
            end
            if (ar_busy && arready === 1'b1) begin
                ar_busy = 1'b0;
                arvalid <= 1'b0;
            end
        end
        if (!done) begin
            num_errors++;
            stop_test();
        end
    endtask
    // Request line first, then identification read
    task automatic iid_chk(input logic [7:0] e);
        @(posedge aclk);
        #1;
        chk(irq, {31'h0, ~e[0]});
        rd_chk(`UIBG_OFF_IID, {24'h0, e}, `UIBG_RESP_OKAY);
    endtask
    task automatic t_reset();
        logic [7:0] offs [5] = '{`UIBG_OFF_IER, `UIBG_OFF_DLL, `UIBG_OFF_DLH, `UIBG_OFF_SCR, `UIBG_OFF_CFG};
        foreach (offs[k]) begin
            rd_chk(offs[k], 32'h0, `UIBG_RESP_OKAY);
        end
        chk(cfg, 32'h0);
        iid_chk(8'h01);
    endtask
    task automatic t_regs();
        axi_write(`UIBG_OFF_SCR, 32'h0000_00a5, `UIBG_RESP_OKAY);
        rd_chk(`UIBG_OFF_SCR, 32'h0000_00a5, `UIBG_RESP_OKAY);
        axi_write(`UIBG_OFF_IER, 32'h0000_00ff, `UIBG_RESP_OKAY);
        rd_chk(`UIBG_OFF_IER, 32'h0000_000f, `UIBG_RESP_OKAY);
        axi_write(`UIBG_OFF_IER, 32'h0000_00f0, `UIBG_RESP_OKAY);
        rd_chk(`UIBG_OFF_IER, 32'h0, `UIBG_RESP_OKAY);
        axi_write(`UIBG_OFF_DLL, 32'h0000_0034, `UIBG_RESP_OKAY);
        axi_write(`UIBG_OFF_DLH, 32'h0000_0012, `UIBG_RESP_OKAY);
        rd_chk(`UIBG_OFF_DLL, 32'h0000_0034, `UIBG_RESP_OKAY);
        rd_chk(`UIBG_OFF_DLH, 32'h0000_0012, `UIBG_RESP_OKAY);
        axi_write(`UIBG_OFF_IID, 32'h0000_00ff, `UIBG_RESP_OKAY);
        iid_chk(8'h01);
        axi_write(8'h3c, 32'h0000_005a, `UIBG_RESP_SLVERR);
        rd_chk(8'h3c, 32'h0, `UIBG_RESP_SLVERR);
        rd_chk(`UIBG_OFF_SCR, 32'h0000_00a5, `UIBG_RESP_OKAY);
    endtask
    // Line, data, transmit and handshake sources active, one enable bit at a time
    task automatic t_gate();
        logic [7:0] gcode [4] = '{8'h04, 8'h02, 8'h06, 8'h00};
        line_in <= 4'h1;
        hs_in <= 4'h2;
        rx_rdy <= 1'b1;
        tx_emp <= 1'b1;
        axi_write(`UIBG_OFF_IER, 32'h0, `UIBG_RESP_OKAY);
        iid_chk(8'h01);
        for (int b = 0; b < 4; b++) begin
            axi_write(`UIBG_OFF_IER, 32'h1 << b, `UIBG_RESP_OKAY);
            iid_chk(gcode[b]);
        end
        axi_write(`UIBG_OFF_IER, 32'h0, `UIBG_RESP_OKAY);
        tx_emp <= 1'b0;
    endtask
    // Sources removed one by one from the top
    task automatic t_prio();
        axi_write(`UIBG_OFF_CFG, 32'h0000_0001, `UIBG_RESP_OKAY);
        rx_to <= 1'b1;
        axi_write(`UIBG_OFF_IER, 32'h0000_000f, `UIBG_RESP_OKAY);
        tx_emp <= 1'b1;
        iid_chk(8'hc6);
        line_in <= 4'h0;
        iid_chk(8'hc4);
        rx_rdy <= 1'b0;
        iid_chk(8'hcc);
        rx_to <= 1'b0;
        iid_chk(8'hc2);
        iid_chk(8'hc0);
        hs_in <= 4'h0;
        iid_chk(8'hc1);
        axi_write(`UIBG_OFF_CFG, 32'h0, `UIBG_RESP_OKAY);
        rx_to <= 1'b1;
        tx_emp <= 1'b0;
        iid_chk(8'h01);
        rx_to <= 1'b0;
        tx_emp <= 1'b1;
        iid_chk(8'h02);
        tx_emp <= 1'b0;
        @(posedge aclk);
        tx_emp <= 1'b1;
        @(posedge aclk);
        tx_wr <= 1'b1;
        @(posedge aclk);
        tx_wr <= 1'b0;
        iid_chk(8'h01);
    endtask
    // Tick count over a window against reference, prescaler and divisor
    task automatic t_baud();
        logic [7:0] cf [6] = '{8'h02, 8'h00, 8'h04, 8'h0c, 8'h06, 8'h02};
        logic [15:0] dv [6] = '{16'h0001, 16'h0001, 16'h0004, 16'h0100, 16'h0002, 16'h0000};
        longint nc [6] = '{1250, 6500, 6500, 13000, 1250, 2000};
        longint num;
        longint den;
        longint exp;
        longint n;
        longint tol;
        for (int k = 0; k < 6; k++) begin
            axi_write(`UIBG_OFF_DLL, {24'h0, dv[k][7:0]}, `UIBG_RESP_OKAY);
            axi_write(`UIBG_OFF_DLH, {24'h0, dv[k][15:8]}, `UIBG_RESP_OKAY);
            axi_write(`UIBG_OFF_CFG, {24'h0, cf[k]}, `UIBG_RESP_OKAY);
            chk(cfg, {28'h0, cf[k][3:0]});
            num = (cf[k][1] == 1'b0 && cf[k][3:2] == 2'h1) ? 8 : 1;
            den = (cf[k][1] == 1'b0 && cf[k][3:2] < 2'h2) ? 13 : 1;
            exp = (dv[k] == 16'h0) ? 0 : nc[k] * `UIBG_REF_KHZ * num / (`UIBG_CLK_KHZ * den * dv[k]);
            tol = (exp == 0) ? 0 : 2;
            n = 0;
            repeat (200) @(posedge aclk);
            repeat (nc[k]) begin
                @(posedge aclk);
                n += (tick === 1'b1) ? 1 : 0;
            end
            check_count++;
            if (n > exp + tol || n + tol < exp) begin
                num_errors++;
                $display("BAD t=%0t ticks=%h exp=%h", $time, n, exp);
            end
        end
    endtask
    initial begin
        num_errors = 0;
        check_count = 0;
        aresetn = 1'b0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {rx_rdy, rx_to, tx_emp, tx_wr} = '0;
        line_in = '0;
        hs_in = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_regs();
        t_gate();
        t_prio();
        t_baud();
        stop_test();
    end
endmodule
